//--- rtl/serial_port_pkg.sv
// package: register map, instruction layout and states of the serial control port
package serial_port_pkg;
  localparam int addr_width = 5;
  localparam int byte_width = 8;
  localparam logic [4:0] addr_config = 5'h00;
  localparam logic [4:0] addr_i_offset_upper = 5'h08;
  localparam logic [4:0] addr_q_offset_upper = 5'h0c;
  localparam logic [4:0] addr_last = 5'h1f;
  localparam logic [4:0] addr_first = 5'h00;
  localparam int bit_dir = 7;
  localparam int bit_count_hi = 6;
  localparam int bit_count_lo = 5;
  localparam int cfg_bit_pin_mode = 7;
  localparam int cfg_bit_lsb_first = 6;
  localparam int cfg_bit_power_down = 3;
  localparam int offset_bit_steer = 7;
  localparam logic [2:0] last_bit = 3'h7;
  localparam logic [7:0] reg_reset = 8'h00;

  typedef struct packed {
    logic read;
    logic [1:0] byte_count;
    logic [4:0] start_addr;
  } instruction_type;

  typedef enum logic [2:0] {
    st_instr = 3'b001,
    st_data = 3'b010,
    st_done = 3'b100
  } state_type;
endpackage : serial_port_pkg

//--- rtl/serial_register_control_port.sv
// serial register control port with its 32-byte register file
`timescale 1ns/1ps
module serial_register_control_port (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic serial_clock,
  input wire logic port_select_n,
  input wire logic serial_data_in,
  output logic serial_data_io_out,
  output logic serial_data_io_oe,
  output logic serial_data_out_pin,
  output logic serial_data_out_pin_oe,
  output logic power_down,
  output logic i_offset_to_complementary,
  output logic q_offset_to_complementary
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sclk_sync;
  logic [1:0] csn_sync;
  logic [1:0] sdi_sync;
  logic sclk_prev;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sclk_sync <= 2'h0;
      csn_sync <= 2'h3;
      sdi_sync <= 2'h0;
      sclk_prev <= 1'b0;
    end
    else
    begin
      sclk_sync <= {sclk_sync[0], serial_clock};
      csn_sync <= {csn_sync[0], port_select_n};
      sdi_sync <= {sdi_sync[0], serial_data_in};
      sclk_prev <= sclk_sync[1];
    end
  end
  logic sel;
  logic rise;
  logic fall;
  assign sel = ~csn_sync[1];
  assign rise = sel && sclk_sync[1] && !sclk_prev;
  assign fall = sel && !sclk_sync[1] && sclk_prev;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic [7:0] regs [0:31];
  serial_port_pkg::state_type state;
  serial_port_pkg::instruction_type instr;
  logic [2:0] bit_cnt;
  logic [1:0] bytes_left;
  logic [4:0] addr;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic lsb_first;
  logic [7:0] next_byte;
  logic [4:0] next_addr;
  logic byte_done;
  logic wr_strobe;
  assign lsb_first = regs[serial_port_pkg::addr_config][serial_port_pkg::cfg_bit_lsb_first];
  // assemble the received byte in the configured bit order
  assign next_byte = lsb_first ? {sdi_sync[1], shift_in[7:1]} : {shift_in[6:0], sdi_sync[1]};
  assign byte_done = rise && (bit_cnt == serial_port_pkg::last_bit);
  assign next_addr = lsb_first ? addr + 5'h01 : addr - 5'h01;
  assign wr_strobe = byte_done && (state == serial_port_pkg::st_data) && !instr.read;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= serial_port_pkg::st_instr;
      instr <= '0;
      bit_cnt <= 3'h0;
      bytes_left <= 2'h0;
      addr <= serial_port_pkg::addr_first;
      shift_in <= serial_port_pkg::reg_reset;
    end
    else if (!sel)
    begin
      // deselect drops any partial byte and restarts
      state <= serial_port_pkg::st_instr;
      bit_cnt <= 3'h0;
      shift_in <= serial_port_pkg::reg_reset;
    end
    else if (rise)
    begin
      case (state)
        serial_port_pkg::st_instr:
        begin
          shift_in <= next_byte;
          bit_cnt <= bit_cnt + 3'h1;
          if (byte_done)
          begin
            instr <= next_byte;
            bytes_left <= next_byte[serial_port_pkg::bit_count_hi:serial_port_pkg::bit_count_lo];
            addr <= next_byte[serial_port_pkg::addr_width-1:0];
            state <= serial_port_pkg::st_data;
          end
        end
        serial_port_pkg::st_data:
        begin
          shift_in <= next_byte;
          bit_cnt <= bit_cnt + 3'h1;
          if (byte_done)
          begin
            addr <= next_addr;
            bytes_left <= bytes_left - 2'h1;
            if (bytes_left == 2'h0)
              state <= serial_port_pkg::st_done;
          end
        end
        serial_port_pkg::st_done:
          state <= serial_port_pkg::st_done;
        default:
          state <= serial_port_pkg::st_instr;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register file, written on the last bit of each data byte of a write
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < (1 << serial_port_pkg::addr_width); i++)
        regs[i] <= serial_port_pkg::reg_reset;
    end
    else if (wr_strobe)
      regs[addr] <= next_byte;
  end

  // ----------------------------------------------------------------
  // read shifter, launched on falling edges
  // ----------------------------------------------------------------
  logic load_pending;
  logic reading;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      load_pending <= 1'b0;
    else if (!sel)
      load_pending <= 1'b0;
    else if (byte_done && state != serial_port_pkg::st_done)
      load_pending <= 1'b1;
    else if (fall)
      load_pending <= 1'b0;
  end
  assign reading = instr.read && (state == serial_port_pkg::st_data);
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      shift_out <= serial_port_pkg::reg_reset;
    else if (fall && load_pending)
      shift_out <= regs[addr];
    else if (fall)
      shift_out <= lsb_first ? {1'b0, shift_out[7:1]} : {shift_out[6:0], 1'b0};
  end
  logic out_bit;
  logic drive;
  logic shared_pin;
  assign out_bit = lsb_first ? shift_out[0] : shift_out[7];
  assign drive = sel && reading && !load_pending;
  assign shared_pin = regs[serial_port_pkg::addr_config][serial_port_pkg::cfg_bit_pin_mode];
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      serial_data_io_out <= 1'b0;
      serial_data_io_oe <= 1'b0;
      serial_data_out_pin <= 1'b0;
      serial_data_out_pin_oe <= 1'b0;
    end
    else
    begin
      serial_data_io_out <= out_bit;
      serial_data_out_pin <= out_bit;
      serial_data_io_oe <= drive && shared_pin;
      serial_data_out_pin_oe <= drive && !shared_pin;
    end
  end

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  // power down leaves this port running; only the flag leaves
  assign power_down = regs[serial_port_pkg::addr_config][serial_port_pkg::cfg_bit_power_down];
  assign i_offset_to_complementary =
    regs[serial_port_pkg::addr_i_offset_upper][serial_port_pkg::offset_bit_steer];
  assign q_offset_to_complementary =
    regs[serial_port_pkg::addr_q_offset_upper][serial_port_pkg::offset_bit_steer];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_deselect_restart: assert property (
    @(posedge clk) disable iff (sys_rst)
    !sel |=> state == serial_port_pkg::st_instr)
    else $error("sequencer not restarted");
  chk_abort_no_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    !sel |-> !wr_strobe ##1 (bit_cnt == '0 && !wr_strobe))
    else $error("partial byte kept after deselect");
  chk_write_immediate: assert property (
    @(posedge clk) disable iff (sys_rst)
    wr_strobe |=> regs[$past(addr)] == $past(next_byte))
    else $error("register not updated");
  chk_instr_to_data: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state == serial_port_pkg::st_instr && byte_done && sel) |=>
    state == serial_port_pkg::st_data && addr == $past(next_byte[serial_port_pkg::addr_width-1:0]))
    else $error("instruction not taken");
  chk_done_holds: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state == serial_port_pkg::st_done && sel) |=> state == serial_port_pkg::st_done || !sel)
    else $error("left done state");
  chk_addr_step: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state == serial_port_pkg::st_data && byte_done && sel && lsb_first) |=> addr == $past(addr) + 5'h01)
    else $error("address not incremented");
  chk_addr_down: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state == serial_port_pkg::st_data && byte_done && sel && !lsb_first) |=> addr == $past(addr) - 5'h01)
    else $error("address not decremented");
  chk_hiz_deselect: assert property (
    @(posedge clk) disable iff (sys_rst)
    !sel ##1 !sel |-> !serial_data_io_oe && !serial_data_out_pin_oe)
    else $error("output driven while deselected");
  chk_no_io_in_mode0: assert property (
    @(posedge clk) disable iff (sys_rst)
    !$past(shared_pin) |-> !serial_data_io_oe)
    else $error("shared pin driven in input mode");
  chk_write_no_drive: assert property (
    @(posedge clk) disable iff (sys_rst)
    (sel && !instr.read) ##1 (sel && !instr.read) |-> !serial_data_io_oe && !serial_data_out_pin_oe)
    else $error("driven during write");
endmodule : serial_register_control_port

//--- sim/serial_host_model.sv
// host model: serial bus master that frames instruction and data bits
`timescale 1ns/1ps
module serial_host_model (
  output logic serial_clock,
  output logic port_select_n,
  output logic host_data,
  input wire logic rx
);
  initial
  begin
    serial_clock = 1'b0;
    port_select_n = 1'b1;
    host_data = 1'b0;
  end

  // bit k of a frame; byte 0 is the instruction, the rest are data bytes
  task automatic frame(input logic [47:0] tx, input logic lsb, input int nbits, output logic [47:0] got);
    int j;
    got = '0;
    port_select_n = 1'b0;
    #40;
    for (int k = 0; k < nbits; k++)
    begin
      j = lsb ? k : (k & ~7) | (7 - (k & 7));
      host_data = tx[j];
      #32 serial_clock = 1'b1;
      got[j] = rx;
      #32 serial_clock = 1'b0;
    end
    #40 port_select_n = 1'b1;
    // released line shows no stale value
    host_data = ~host_data;
    #40;
  endtask : frame
endmodule : serial_host_model

//--- sim/serial_register_control_port_tb.sv
// self-checking bench of the serial register control port
`timescale 1ns/1ps
module serial_register_control_port_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic both_on = 1'b0;
  logic sclk, sel_n, host_data, io_out, io_oe, pin, pin_oe, pd, i_cmp, q_cmp;
  logic [31:0] d;
  logic [47:0] r;
  int miscompares = 0;
  int num_checks = 0;
  wire logic sd = io_oe ? io_out : host_data;
  wire logic rx = io_oe ? io_out : (pin_oe ? pin : ~host_data);

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  serial_register_control_port i_serial_register_control_port (.clk(clk), .sys_rst(sys_rst),
    .serial_clock(sclk), .port_select_n(sel_n), .serial_data_in(sd), .serial_data_io_out(io_out),
    .serial_data_io_oe(io_oe), .serial_data_out_pin(pin), .serial_data_out_pin_oe(pin_oe),
    .power_down(pd), .i_offset_to_complementary(i_cmp), .q_offset_to_complementary(q_cmp));
  serial_host_model i_serial_host_model (.serial_clock(sclk), .port_select_n(sel_n),
    .host_data(host_data), .rx(rx));

  always @(posedge clk)
    if (io_oe & pin_oe) both_on <= 1'b1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  function automatic logic [7:0] ins(input logic is_rd, input int n, input logic [4:0] a);
    return {is_rd, 2'(n - 1), a};
  endfunction : ins

  task wr(input logic [4:0] a, input int n, input logic [31:0] v, input logic lsb);
    i_serial_host_model.frame({8'h00, v, ins(1'b0, n, a)}, lsb, 8 + 8 * n, r);
  endtask : wr

  task rd(input logic [4:0] a, input int n, input logic lsb);
    i_serial_host_model.frame({40'h0, ins(1'b1, n, a)}, lsb, 8 + 8 * n, r);
    d = r[39:8];
  endtask : rd

  task t_reset;
    chk({pd, i_cmp, q_cmp, io_oe, pin_oe}, 32'h0);
    rd(5'h08, 1, 1'b0);
    chk(d, 32'h0);
  endtask : t_reset

  task t_single;
    wr(5'h08, 1, 32'h80, 1'b0);
    chk(i_cmp, 1'b1);
    wr(5'h0c, 2, 32'h3c81, 1'b0);
    chk(q_cmp, 1'b1);
    rd(5'h0b, 1, 1'b0);
    chk(d, 32'h3c);
  endtask : t_single

  task t_msb4;
    wr(5'h01, 4, 32'h44220033, 1'b0);
    rd(5'h01, 4, 1'b0);
    chk(d, 32'h44220033);
    rd(5'h1e, 1, 1'b0);
    chk(d, 32'h44);
  endtask : t_msb4

  task t_lsb;
    wr(5'h00, 1, 32'h48, 1'b0);
    chk(pd, 1'b1);
    wr(5'h1f, 3, 32'h0748a5, 1'b1);
    rd(5'h1f, 3, 1'b1);
    chk(d, 32'h0748a5);
    wr(5'h00, 1, 32'h00, 1'b1);
    chk(pd, 1'b0);
  endtask : t_lsb

  task t_abort;
    i_serial_host_model.frame({40'h0, ins(1'b0, 1, 5'h0c)}, 1'b0, 6, r);
    i_serial_host_model.frame({40'h0, ins(1'b0, 1, 5'h0c)}, 1'b0, 14, r);
    chk(q_cmp, 1'b1);
    wr(5'h0c, 1, 32'h00, 1'b0);
    chk(q_cmp, 1'b0);
  endtask : t_abort

  task t_extra;
    i_serial_host_model.frame({24'h0, 8'hff, 8'h00, ins(1'b0, 1, 5'h08)}, 1'b0, 24, r);
    chk(i_cmp, 1'b0);
    rd(5'h07, 1, 1'b0);
    chk(d, 32'h00);
  endtask : t_extra

  task t_shared;
    wr(5'h00, 1, 32'h80, 1'b0);
    rd(5'h1e, 1, 1'b0);
    chk(d, 32'h44);
    wr(5'h00, 1, 32'h00, 1'b0);
    chk(both_on, 1'b0);
  endtask : t_shared

  task report_and_stop;
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (2) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    t_single();
    t_msb4();
    t_lsb();
    t_abort();
    t_extra();
    t_shared();
    report_and_stop();
  end

  initial
  begin
    #300000;
    miscompares++;
    report_and_stop();
  end
endmodule : serial_register_control_port_tb
